/* inc/tucm_regs.svh */
`ifndef TUCM_REGS_SVH
`define TUCM_REGS_SVH

// tuning value layout: coarse in 10 kHz counts, fine in 100 Hz counts
`define TUCM_COARSE_W      9
`define TUCM_FINE_W        7
`define TUCM_COARSE_TOP    9'h18f
`define TUCM_FINE_MOD      7'h64
`define TUCM_LIN_MOD       16'h9c40
`define TUCM_LIN_W         16

// loop divider: 300 at 144.000 MHz, one count per 10 kHz
`define TUCM_DIV_BASE      10'h12c
`define TUCM_DIV_W         10

// band segment edges, 1 MHz = 100 coarse counts
`define TUCM_SEG1_COARSE   9'h064
`define TUCM_SEG2_COARSE   9'h0c8
`define TUCM_SEG3_COARSE   9'h12c

// step sizes in 100 Hz units
`define TUCM_STEP_100HZ    7'h01
`define TUCM_STEP_1KHZ     7'h0a
`define TUCM_STEP_10KHZ    7'h64

// reference chain: three cascaded stages then a toggle to 10 kHz
`define TUCM_CLK_FREQ_HZ   40000000
`define TUCM_REF_FREQ_HZ   10000
`define TUCM_STG1_DIV      4'h9
`define TUCM_STG2_DIV      4'h9
`define TUCM_STG3_DIV \
    (5'((`TUCM_CLK_FREQ_HZ / `TUCM_REF_FREQ_HZ) / (10 * 10 * 2)) - 5'h01)

// pin synchroniser
`define TUCM_PIN_W         6

`endif

/* inc/tucm_pkg.sv */
package tucm_pkg;

    typedef enum logic
    {
        TUCM_MODE_SIDEBAND,
        TUCM_MODE_FM
    } tucm_mode_e;

    typedef struct packed
    {
        logic [8:0] coarse;
        logic [6:0] fine;
    } tucm_tune_s;

    typedef struct packed
    {
        logic encPulse;
        logic encCw;
        logic memPressed;
        logic viewMem;
        logic modeFm;
        logic fastStep;
    } tucm_pins_s;

endpackage : tucm_pkg

/* core/tucm_pin_sync.sv */
`timescale 1ns/1ps
`include "tucm_regs.svh"

module tucm_pin_sync
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // raw pins
    input  wire logic [`TUCM_PIN_W-1:0] pinRaw,
    // filtered levels
    output logic      [`TUCM_PIN_W-1:0] pinLevel
);

    logic [`TUCM_PIN_W-1:0] sync1_r;
    logic [`TUCM_PIN_W-1:0] sync2_r;
    logic [`TUCM_PIN_W-1:0] sync3_r;
    logic [`TUCM_PIN_W-1:0] level_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end
        else
        begin
            sync1_r <= pinRaw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // a bit moves only once second and third stage agree
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            level_r <= '0;
        else
        begin
            for (int i = 0; i < `TUCM_PIN_W; i++)
            begin
                if (sync2_r[i] == sync3_r[i])
                    level_r[i] <= sync3_r[i];
            end
        end
    end

    assign pinLevel = level_r;

endmodule : tucm_pin_sync

/* core/tucm_tuning_ctrl.sv */
`timescale 1ns/1ps
`include "tucm_regs.svh"

// Operation
// R1 - Each pulse moves the counter one step and it holds between pulses; the code drops a pulse that lands on the swap cycle.
// R2 - One selected value feeds both the loop divider and the display.
// R3 - The data selector presents either the counter or the memory latch.
// R4 - On release of the memory switch the latch captures the counter.
// R5 - In that event the counter takes the old latch value, so both swap.
// R6 - Sub-10 kHz steps are 100 Hz or 1 kHz in sideband, 1 kHz in FM.
// R7 - Changes of 10 kHz and more go to the divide ratio, not the fine path.
// R8 - The encoder gives 50 pulses per dial revolution.
// R9 - The divide ratio is 300 at 144.000 MHz and 400 at 145.000 MHz.
// R10 - Three divider stages make the 10 kHz loop reference from the clock.
// R11 - The sub-10 kHz digits drive the offset oscillator D/A code.
// R12 - A band-segment output changes every 1 MHz of tuned frequency.
// R13 - In FM the fast step is 10 kHz and the normal step 1 kHz.
// R14 - In sideband and CW the fast step is 1 kHz and the normal step 100 Hz.
// R15 - Clockwise counts up, counter-clockwise counts down.
// R16 - Fine-digit carries and borrows pass into the divide-ratio value.
module tucm_tuning_ctrl
(
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // front panel and encoder pins
    input  wire tucm_pkg::tucm_pins_s    pins,
    // loop divider and display
    output tucm_pkg::tucm_tune_s         displayValue,
    output logic [`TUCM_DIV_W-1:0]       divRatio,
    output logic                         memShown,
    // offset oscillator and converter
    output logic [`TUCM_FINE_W-1:0]      dacCode,
    output logic [1:0]                   bandSeg,
    // loop reference
    output logic                         refClk
);

    function automatic logic [6:0] stepUnits(input logic fm,
                                             input logic fast);
        if (fm)
            stepUnits = fast ? `TUCM_STEP_10KHZ : `TUCM_STEP_1KHZ;
        else
            stepUnits = fast ? `TUCM_STEP_1KHZ : `TUCM_STEP_100HZ;
    endfunction : stepUnits

    function automatic tucm_pkg::tucm_tune_s stepValue(
        input tucm_pkg::tucm_tune_s v,
        input logic [6:0]           step,
        input logic                 up);
        logic [7:0] sum;
        sum = 8'(v.fine) + 8'(step);
        stepValue = v;
        if (up)
        begin
            if (sum >= 8'(`TUCM_FINE_MOD))
            begin
                stepValue.fine   = 7'(sum - 8'(`TUCM_FINE_MOD));
                stepValue.coarse = (v.coarse == `TUCM_COARSE_TOP) ?
                                   9'h000 : v.coarse + 9'h001;
            end
            else
                stepValue.fine = 7'(sum);
        end
        else if (v.fine >= step)
            stepValue.fine = v.fine - step;
        else
        begin
            stepValue.fine   = v.fine + `TUCM_FINE_MOD - step;
            stepValue.coarse = (v.coarse == 9'h000) ?
                               `TUCM_COARSE_TOP : v.coarse - 9'h001;
        end
    endfunction : stepValue

    function automatic logic [1:0] segOf(input logic [8:0] coarse);
        if (coarse < `TUCM_SEG1_COARSE)
            segOf = 2'h0;
        else if (coarse < `TUCM_SEG2_COARSE)
            segOf = 2'h1;
        else if (coarse < `TUCM_SEG3_COARSE)
            segOf = 2'h2;
        else
            segOf = 2'h3;
    endfunction : segOf

    function automatic logic [15:0] linOf(input tucm_pkg::tucm_tune_s v);
        linOf = 16'(v.coarse) * 16'(`TUCM_FINE_MOD) + 16'(v.fine);
    endfunction : linOf

    tucm_pkg::tucm_pins_s pinLevel;
    tucm_pkg::tucm_pins_s pinPrev_r;
    tucm_pkg::tucm_tune_s count_r;
    tucm_pkg::tucm_tune_s latch_r;
    tucm_pkg::tucm_tune_s count_nxt;
    tucm_pkg::tucm_tune_s selValue;
    tucm_pkg::tucm_tune_s display_r;
    tucm_pkg::tucm_mode_e mode;
    logic [`TUCM_DIV_W-1:0]  div_r;
    logic [`TUCM_FINE_W-1:0] dac_r;
    logic [1:0]              seg_r;
    logic                    memShown_r;
    logic [3:0]              stg1_r;
    logic [3:0]              stg2_r;
    logic [4:0]              stg3_r;
    logic                    ref_r;
    logic                    stepEv;
    logic                    swapEv;
    logic [6:0]              step;

    tucm_pin_sync u_pin_sync
    (
        .clk      (clk),
        .rst_n    (rst_n),
        .pinRaw   (pins),
        .pinLevel (pinLevel)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pinPrev_r <= '0;
        else
            pinPrev_r <= pinLevel;
    end

    assign mode   = pinLevel.modeFm ? tucm_pkg::TUCM_MODE_FM
                                    : tucm_pkg::TUCM_MODE_SIDEBAND;
    assign stepEv = pinLevel.encPulse && !pinPrev_r.encPulse;     // [R1]
    // swap on the release, so a held switch does nothing yet
    assign swapEv = !pinLevel.memPressed && pinPrev_r.memPressed; // [R4]
    assign step   = stepUnits(mode == tucm_pkg::TUCM_MODE_FM,
                              pinLevel.fastStep); // [R6] [R13] [R14]

    // fine digits carry straight into the coarse count
    always_comb
    begin
        count_nxt = count_r;
        if (stepEv)
            count_nxt = stepValue(count_r, step,
                                  pinLevel.encCw); // [R15] [R16] [R7]
    end

    // a pulse landing on the swap cycle is dropped; swap has priority
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count_r <= '0;
        else if (swapEv)
            count_r <= latch_r;                                   // [R5]
        else
            count_r <= count_nxt;                                 // [R1]
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            latch_r <= '0;
        else if (swapEv)
            latch_r <= count_r;                                   // [R4]
    end

    assign selValue = pinLevel.viewMem ? latch_r : count_r;       // [R3]

    // divider, display, converter and segment all load from one source
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            display_r  <= '0;
            div_r      <= `TUCM_DIV_BASE;
            dac_r      <= '0;
            seg_r      <= '0;
            memShown_r <= 1'b0;
        end
        else
        begin
            display_r  <= selValue;                               // [R2]
            div_r      <= `TUCM_DIV_BASE + 10'(selValue.coarse);  // [R9] [R7]
            dac_r      <= selValue.fine;                          // [R11]
            seg_r      <= segOf(selValue.coarse);                 // [R12]
            memShown_r <= pinLevel.viewMem;                       // [R3]
        end
    end

    // reference chain: /10, /10, /20, then a toggle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stg1_r <= '0;
            stg2_r <= '0;
            stg3_r <= '0;
            ref_r  <= 1'b0;
        end
        else
        begin
            stg1_r <= (stg1_r == `TUCM_STG1_DIV) ? 4'h0 : stg1_r + 4'h1;
            if (stg1_r == `TUCM_STG1_DIV)
            begin
                stg2_r <= (stg2_r == `TUCM_STG2_DIV) ? 4'h0 : stg2_r + 4'h1;
                if (stg2_r == `TUCM_STG2_DIV)
                begin
                    stg3_r <= (stg3_r == `TUCM_STG3_DIV) ?
                              5'h00 : stg3_r + 5'h01;             // [R10]
                    if (stg3_r == `TUCM_STG3_DIV)
                        ref_r <= !ref_r;                          // [R10]
                end
            end
        end
    end

    assign displayValue = display_r;
    assign divRatio     = div_r;
    assign dacCode      = dac_r;
    assign bandSeg      = seg_r;
    assign memShown     = memShown_r;
    assign refClk       = ref_r;

    // checks
    logic [15:0] linNow;
    logic [15:0] linUp;
    logic [15:0] linDown;
    assign linNow  = linOf(count_r);
    assign linUp   = (linNow + 16'(step) >= `TUCM_LIN_MOD) ?
                     linNow + 16'(step) - `TUCM_LIN_MOD : linNow + 16'(step);
    assign linDown = (linNow >= 16'(step)) ?
                     linNow - 16'(step) : linNow + `TUCM_LIN_MOD - 16'(step);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_count_hold: assert property ( // [R1]
        !stepEv && !swapEv |=> $stable(count_r))
        else $error("counter moved without a pulse");

    chk_count_up: assert property ( // [R15]
        stepEv && !swapEv && pinLevel.encCw |=> linNow == $past(linUp))
        else $error("clockwise step wrong");

    chk_count_down: assert property ( // [R16]
        stepEv && !swapEv && !pinLevel.encCw |=> linNow == $past(linDown))
        else $error("counter-clockwise step wrong");

    chk_step_size: assert property ( // [R14]
        !pinLevel.modeFm && !pinLevel.fastStep |-> step == 7'h01)
        else $error("sideband normal step not 100 Hz");

    chk_fm_fast: assert property ( // [R13]
        pinLevel.modeFm && pinLevel.fastStep |-> step == 7'h64)
        else $error("fm fast step not 10 kHz");

    chk_mid_step: assert property ( // [R6]
        pinLevel.modeFm != pinLevel.fastStep |-> step == `TUCM_STEP_1KHZ)
        else $error("1 kHz step wrong");

    chk_swap_exchange: assert property ( // [R5]
        swapEv |=> latch_r == $past(count_r) && count_r == $past(latch_r))
        else $error("memory swap did not exchange");

    chk_latch_hold: assert property ( // [R4]
        !swapEv |=> $stable(latch_r))
        else $error("latch changed without release");

    chk_select_route: assert property ( // [R3]
        ##1 display_r == ($past(pinLevel.viewMem) ?
                          $past(latch_r) : $past(count_r)))
        else $error("selector output wrong");

    chk_div_display: assert property ( // [R9]
        div_r == `TUCM_DIV_BASE + 10'(display_r.coarse)
        && dac_r == display_r.fine)
        else $error("divider and display disagree");

    chk_band_seg: assert property ( // [R12]
        seg_r == 2'(linOf(display_r) / 16'h2710))
        else $error("band segment wrong");

    chk_fine_range: assert property ( // [R11]
        count_r.fine < `TUCM_FINE_MOD && count_r.coarse <= `TUCM_COARSE_TOP)
        else $error("tuning value out of range");

    chk_ref_toggle: assert property ( // [R10]
        $changed(ref_r) |-> $past(stg1_r) == `TUCM_STG1_DIV
        && $past(stg2_r) == `TUCM_STG2_DIV && $past(stg3_r) == `TUCM_STG3_DIV)
        else $error("reference toggled off count");

endmodule : tucm_tuning_ctrl

/* sim/tucm_encoder_model.sv */
`timescale 1ns/1ps

module tucm_encoder_model
(
    // clock
    input  wire logic clk,
    // encoder pins
    output logic      encPulse,
    output logic      encCw
);
    initial
    begin
        encPulse = 1'b0;
        encCw    = 1'b0;
    end

    // one dial count; direction settles long before the edge
    // so the filtered direction is never caught mid-change
    task automatic turn(input logic cw, input int hiLen, input int loLen);
        @(negedge clk);
        encCw <= cw;
        repeat (6) @(negedge clk);
        encPulse <= 1'b1;
        repeat (hiLen) @(negedge clk);
        encPulse <= 1'b0;
        repeat (loLen) @(negedge clk);
    endtask : turn

    // full dial revolution at the quickest legal rate
    task automatic revolution(input logic cw);
        repeat (50) turn(cw, 3, 3);
    endtask : revolution
endmodule : tucm_encoder_model

/* sim/test_tuning_updown_counter_memswap.sv */
`timescale 1ns/1ps
`include "tucm_regs.svh"

module test_tuning_updown_counter_memswap;
    logic                 clk;
    logic                 rst_n;
    logic                 encPulse;
    logic                 encCw;
    logic                 memPressed;
    logic                 viewMem;
    logic                 modeFm;
    logic                 fastStep;
    tucm_pkg::tucm_pins_s pins;
    tucm_pkg::tucm_tune_s displayValue;
    logic [9:0]           divRatio;
    logic                 memShown;
    logic [6:0]           dacCode;
    logic [1:0]           bandSeg;
    logic                 refClk;
    int                   fails;
    int                   checksDone;
    logic [31:0]          seed;
    int                   cntLin;
    int                   latLin;

    assign pins = {encPulse, encCw, memPressed, viewMem, modeFm, fastStep};

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    tucm_tuning_ctrl i_dut
    (
        .clk          (clk),
        .rst_n        (rst_n),
        .pins         (pins),
        .displayValue (displayValue),
        .divRatio     (divRatio),
        .memShown     (memShown),
        .dacCode      (dacCode),
        .bandSeg      (bandSeg),
        .refClk       (refClk)
    );

    tucm_encoder_model i_enc
    (
        .clk      (clk),
        .encPulse (encPulse),
        .encCw    (encCw)
    );

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift

    // step size in 100 Hz units
    function automatic int stepOf(logic fm, logic fast);
        if (fm)
            return fast ? 100 : 10;
        return fast ? 10 : 1;
    endfunction : stepOf

    task automatic chkVal(string name, logic [15:0] exp, logic [15:0] got);
        checksDone++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chkVal

    task automatic chkTune(string name, tucm_pkg::tucm_tune_s exp,
                           tucm_pkg::tucm_tune_s got);
        checksDone++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chkTune

    task automatic summarize();
        $display("checks %0d fails %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    task automatic checkAll();
        tucm_pkg::tucm_tune_s e;
        int                   shown;
        shown = viewMem ? latLin : cntLin;
        e.coarse = 9'(shown / 100);
        e.fine = 7'(shown % 100);
        chkTune("displayValue", e, displayValue);
        chkVal("divRatio", 16'(300 + shown / 100), {6'h00, divRatio});
        chkVal("dacCode", 16'(shown % 100), {9'h000, dacCode});
        chkVal("bandSeg", 16'(shown / 10000), {14'h0000, bandSeg});
        chkVal("memShown", {15'h0000, viewMem}, {15'h0000, memShown});
    endtask : checkAll

    task automatic settle();
        repeat (8) @(negedge clk);
    endtask : settle

    task automatic step(logic cw, int hiLen, int loLen);
        int s;
        i_enc.turn(cw, hiLen, loLen);
        s = stepOf(modeFm, fastStep);
        cntLin = cw ? (cntLin + s) % 40000 : (cntLin + 40000 - s) % 40000;
    endtask : step

    task automatic setPins(logic fm, logic fast, logic view);
        @(negedge clk);
        modeFm <= fm;
        fastStep <= fast;
        viewMem <= view;
        settle();
    endtask : setPins

    task automatic swap();
        int t;
        @(negedge clk);
        memPressed <= 1'b1;
        repeat (6) @(negedge clk);
        memPressed <= 1'b0;
        t = latLin;
        latLin = cntLin;
        cntLin = t;
        settle();
    endtask : swap

    // half period of the loop reference, bounded both ways
    task automatic measureRef();
        int   n;
        logic prev;
        n = 0;
        prev = refClk;
        while (refClk === prev && n < 2100)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 2100)
        begin
            fails++;
            $display("FAIL refClk first toggle expected %0d seen %0d", 2000, n);
        end
        n = 0;
        prev = refClk;
        while (refClk === prev && n < 2100)
        begin
            @(negedge clk);
            n++;
        end
        chkVal("refClk half period", 16'd2000, 16'(n));
        if (n >= 2100)
            summarize();
    endtask : measureRef

    initial
    begin
        logic [31:0] r;
        {memPressed, viewMem, modeFm, fastStep} = 4'h0;
        rst_n = 1'b0;
        fails = 0;
        checksDone = 0;
        seed = 32'h4eeb93f6;
        cntLin = 0;
        latLin = 0;
        repeat (6) @(negedge clk);
        checkAll();
        rst_n <= 1'b1;
        // borrow below the band bottom wraps to the top
        step(1'b0, 3, 3);
        settle();
        checkAll();
        step(1'b1, 3, 3);
        settle();
        checkAll();
        setPins(1'b1, 1'b1, 1'b0);
        repeat (3) step(1'b1, 4, 5);
        settle();
        checkAll();
        setPins(1'b1, 1'b0, 1'b0);
        step(1'b1, 3, 3);
        repeat (2) step(1'b0, 3, 3);
        settle();
        checkAll();
        setPins(1'b0, 1'b1, 1'b0);
        repeat (2) step(1'b0, 3, 4);
        settle();
        checkAll();
        setPins(1'b0, 1'b0, 1'b0);
        i_enc.revolution(1'b1);
        cntLin = (cntLin + 50) % 40000;
        settle();
        checkAll();
        swap();
        checkAll();
        // counting while the latch is shown stays hidden
        setPins(1'b0, 1'b1, 1'b1);
        checkAll();
        step(1'b1, 3, 3);
        settle();
        checkAll();
        setPins(1'b0, 1'b0, 1'b0);
        checkAll();
        repeat (40)
        begin
            r = xorshift();
            if (r[1:0] == 2'h0)
                swap();
            else
            begin
                setPins(r[2], r[3], r[4]);
                repeat (int'(r[6:5]) + 1)
                    step(r[12], 3 + int'(r[9:8]), 3 + int'(r[11:10]));
                settle();
            end
            checkAll();
        end
        measureRef();
        summarize();
    end
endmodule : test_tuning_updown_counter_memswap
